// *** include/fc_flash_regs.vh ***
/*
 * register offsets, fields, command codes and timing counts of the flash host.
 * assumes a 25 MHz system clock and a flash reached over its asynchronous pins.
 */
`ifndef FC_FLASH_REGS_VH
`define FC_FLASH_REGS_VH
// ****************************************
// register map (byte addresses)
// ****************************************
`define FC_REG_CTRL 8'h00
`define FC_REG_ADDR 8'h04
`define FC_REG_WDATA 8'h08
`define FC_REG_STATUS 8'h0c
`define FC_REG_RDATA 8'h10
// ctrl fields
`define FC_CTRL_HV_BIT 8
// ****************************************
// host commands written to ctrl[3:0]
// ****************************************
`define FC_OP_NONE 4'h0
`define FC_OP_PROG 4'h1
`define FC_OP_CHIP_ERASE 4'h2
`define FC_OP_SECT_ERASE 4'h3
`define FC_OP_LOCKOUT 4'h4
`define FC_OP_BYPASS 4'h5
`define FC_OP_SUSPEND 4'h6
`define FC_OP_RESUME 4'h7
`define FC_OP_ID_ENTRY 4'h8
`define FC_OP_ID_EXIT 4'h9
`define FC_OP_ID_EXIT_SHORT 4'ha
`define FC_OP_READ 4'hb
`define FC_OP_HW_RESET 4'hc
// ****************************************
// flash command bytes and unlock addresses
// ****************************************
`define FC_UNLOCK_ADDR1 20'h05555
`define FC_UNLOCK_ADDR2 20'h02aaa
`define FC_UNLOCK_DATA1 16'h00aa
`define FC_UNLOCK_DATA2 16'h0055
`define FC_CODE_PROG 16'h00a0
`define FC_CODE_ERASE 16'h0080
`define FC_CODE_CHIP 16'h0010
`define FC_CODE_SECTOR 16'h0030
`define FC_CODE_LOCK 16'h0040
`define FC_CODE_SUSPEND 16'h00b0
`define FC_CODE_RESUME 16'h0030
`define FC_CODE_ID_ENTRY 16'h0090
`define FC_CODE_ID_EXIT 16'h00f0
// ****************************************
// timing
// ****************************************
`define FC_CLK_NS 40
`define FC_ACCESS_NS 70
`define FC_NOISE_NS 15
`define FC_SUSPEND_US 15
`define FC_RST_PULSE_NS 500
`define FC_BUSY_SETTLE_NS 200
`define FC_ACC_CYC ((`FC_ACCESS_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_WE_CYC (((`FC_NOISE_NS + `FC_CLK_NS - 1) / `FC_CLK_NS) + 1)
`define FC_SUSPEND_CYC ((`FC_SUSPEND_US * 1000 + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_RST_CYC ((`FC_RST_PULSE_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_SETTLE_CYC ((`FC_BUSY_SETTLE_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`endif

// *** rtl/fc_bus_cycle.v ***
/*
 * one asynchronous flash bus cycle (write or read) on registered pins.
 * assumes the flash data are stable once the access time has passed.
 */
`timescale 1ns/1ps
`include "fc_flash_regs.vh"
module fc_bus_cycle (
	// clock and reset
	input wire clk,
	input wire rst,
	// request
	input wire start,
	input wire is_read,
	input wire [19:0] addr,
	input wire [15:0] wdata,
	output wire done,
	output reg [15:0] rdata_reg,
	// flash pins
	output reg [19:0] pin_addr_reg,
	output reg [15:0] pin_dq_out_reg,
	output reg pin_dq_oe_reg,
	output reg pin_ce_n_reg,
	output reg pin_oe_n_reg,
	output reg pin_we_n_reg,
	input wire [15:0] pin_dq_in
);
	// ****************************************
	// cycle state
	// ****************************************
	localparam ST_IDLE = 3'd0;
	localparam ST_SETUP = 3'd1;
	localparam ST_STROBE = 3'd2;
	localparam ST_HOLD = 3'd3;
	localparam ST_ACCESS = 3'd4;
	localparam ST_END = 3'd5;
	localparam integer WE_CYC_INT = `FC_WE_CYC;
	localparam integer ACC_CYC_INT = `FC_ACC_CYC;
	// both counts are small; the low four bits carry them whole
	localparam [3:0] WE_CYC = WE_CYC_INT[3:0];
	localparam [3:0] ACC_CYC = ACC_CYC_INT[3:0];
	reg [2:0] state_reg; // current phase
	reg [3:0] cnt_reg; // phase length counter
	reg read_reg; // cycle kind held for the whole cycle
	assign done = (state_reg == ST_END);
	// phase sequencing and pin drive
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			read_reg <= 1'b0;
			rdata_reg <= 16'h0000;
			pin_addr_reg <= 20'h00000;
			pin_dq_out_reg <= 16'h0000;
			pin_dq_oe_reg <= 1'b0;
			pin_ce_n_reg <= 1'b1;
			pin_oe_n_reg <= 1'b1;
			pin_we_n_reg <= 1'b1;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (start) begin
					// address settles before the write strobe falls; chip enable and a read's output enable fall with it
					pin_addr_reg <= addr;
					pin_dq_out_reg <= wdata;
					pin_dq_oe_reg <= ~is_read;
					read_reg <= is_read;
					pin_ce_n_reg <= 1'b0;
					// output enable stays high through a write
					pin_oe_n_reg <= ~is_read;
					state_reg <= ST_SETUP;
				end
			end
			ST_SETUP: begin
				cnt_reg <= 4'h0;
				if (read_reg) begin
					state_reg <= ST_ACCESS;
				end else begin
					pin_we_n_reg <= 1'b0;
					state_reg <= ST_STROBE;
				end
			end
			ST_STROBE: begin
				// strobe held well beyond the noise filter
				if (cnt_reg == WE_CYC - 4'h1) begin
					pin_we_n_reg <= 1'b1;
					state_reg <= ST_HOLD;
				end else begin
					cnt_reg <= cnt_reg + 4'h1;
				end
			end
			ST_HOLD: begin
				// data kept past the rising strobe edge
				pin_ce_n_reg <= 1'b1;
				state_reg <= ST_END;
			end
			ST_ACCESS: begin
				if (cnt_reg == ACC_CYC) begin
					rdata_reg <= pin_dq_in;
					pin_ce_n_reg <= 1'b1;
					pin_oe_n_reg <= 1'b1;
					state_reg <= ST_END;
				end else begin
					cnt_reg <= cnt_reg + 4'h1;
				end
			end
			ST_END: begin
				// one recovery cycle with all strobes high
				pin_dq_oe_reg <= 1'b0;
				state_reg <= ST_IDLE;
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // fc_bus_cycle

// *** rtl/fc_axil_slave.v ***
/*
 * axi4-lite slave front end: one write and one read at a time.
 * assumes the owner decodes addresses combinationally and flags unmapped ones.
 */
`timescale 1ns/1ps
module fc_axil_slave (
	// clock and reset
	input wire clk,
	input wire rst,
	// axi4-lite
	input wire [7:0] awaddr,
	input wire awvalid,
	output wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	output reg [1:0] bresp_reg,
	output reg bvalid_reg,
	input wire bready,
	input wire [7:0] araddr,
	input wire arvalid,
	output wire arready,
	output reg [31:0] rdata_reg,
	output reg [1:0] rresp_reg,
	output reg rvalid_reg,
	input wire rready,
	// register side
	output wire wr_en,
	output reg [7:0] wr_addr_reg,
	output reg [31:0] wr_data_reg,
	output reg [3:0] wr_strb_reg,
	input wire wr_ok,
	output wire [7:0] rd_addr,
	input wire [31:0] rd_data,
	input wire rd_ok
);
	reg aw_full_reg; // write address held
	reg w_full_reg; // write data held
	// channels close while a response is pending
	assign awready = ~aw_full_reg & ~bvalid_reg;
	assign wready = ~w_full_reg & ~bvalid_reg;
	assign arready = ~rvalid_reg;
	assign wr_en = aw_full_reg & w_full_reg;
	assign rd_addr = araddr;
	// write channel: address and data in either order
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 32'h00000000;
			wr_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'b00;
		end else begin
			if (awvalid & awready) begin
				aw_full_reg <= 1'b1;
				wr_addr_reg <= awaddr;
			end
			if (wvalid & wready) begin
				w_full_reg <= 1'b1;
				wr_data_reg <= wdata;
				wr_strb_reg <= wstrb;
			end
			if (wr_en) begin
				// unmapped offsets answer slverr
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? 2'b00 : 2'b10;
			end else if (bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end
	// read channel: data one cycle after the address
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= 2'b00;
		end else if (arvalid & arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_ok ? rd_data : 32'h00000000;
			rresp_reg <= rd_ok ? 2'b00 : 2'b10;
		end else if (rready) begin
			rvalid_reg <= 1'b0;
		end
	end
endmodule // fc_axil_slave

// *** rtl/fc_flash_host.v ***
/*
 * flash host controller: turns register commands into flash command sequences.
 * assumes one flash on the pins; ready pin wired-or with an external pull-up.
 */
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
// Behaviour
// - program is four writes ending at target
// - lockout is six writes, sixth data 40
// - suspend is one write of b0
// - resume writes 30 with plane address
// - chip and sector erase six-write sequences
// - id mode entry and two exit forms
`timescale 1ns/1ps
`include "fc_flash_regs.vh"
module fc_flash_host (
	// clock and reset
	input wire SYS_CLK,
	input wire RST,
	// axi4-lite write
	input wire [7:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	output wire [1:0] S_AXI_BRESP,
	output wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// axi4-lite read
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output wire [31:0] S_AXI_RDATA,
	output wire [1:0] S_AXI_RRESP,
	output wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// flash pins
	output wire [19:0] FL_ADDR,
	output wire [15:0] FL_DQ_OUT,
	output wire FL_DQ_OE,
	input wire [15:0] FL_DQ_IN,
	output wire FL_CE_N,
	output wire FL_OE_N,
	output wire FL_WE_N,
	output wire FL_RESET_N,
	output wire FL_HV_EN,
	input wire FL_READY_IN
);
	// ****************************************
	// sequencer states and constants
	// ****************************************
	localparam ST_IDLE = 3'd0;
	localparam ST_CYCLE = 3'd1;
	localparam ST_SETTLE = 3'd2;
	localparam ST_WAIT_RDY = 3'd3;
	localparam ST_SUSPEND = 3'd4;
	localparam ST_RESET = 3'd5;
	localparam integer SUSPEND_INT = `FC_SUSPEND_CYC;
	localparam integer RST_INT = `FC_RST_CYC;
	localparam integer SETTLE_INT = `FC_SETTLE_CYC;
	// all waits fit the nine-bit wait counter
	localparam [8:0] SUSPEND_CYC = SUSPEND_INT[8:0];
	localparam [8:0] RST_CYC = RST_INT[8:0];
	localparam [8:0] SETTLE_CYC = SETTLE_INT[8:0];
	// ****************************************
	// declarations
	// ****************************************
	reg [2:0] state_reg; // sequencer state
	reg [3:0] op_reg; // command under way
	reg [2:0] step_reg; // bus cycle within the sequence
	reg [8:0] wait_reg; // settle, suspend and reset counter
	reg [19:0] addr_reg; // target address from software
	reg [15:0] wdata_reg; // program data from software
	reg hv_reg; // high voltage override request
	reg bypass_reg; // flash is in single-pulse program mode
	reg suspended_reg; // an erase is suspended
	reg refused_reg; // last command was refused
	reg poll_reg; // polling bit of the last read
	reg toggle_reg; // toggle bit changed between reads
	reg sus_toggle_reg; // suspend toggle changed between reads
	reg [15:0] last_rd_reg; // last data read from the flash
	reg reset_n_reg; // flash reset pin drive
	reg [2:0] rdy_sync_reg; // ready pin synchroniser
	reg rdy_level_reg; // filtered ready level
	reg cyc_start_reg; // start pulse to the bus cycle
	wire cyc_done; // bus cycle finished
	wire [15:0] cyc_rdata; // data of the last read cycle
	wire wr_en; // register write strobe
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [7:0] rd_addr;
	reg [31:0] rd_data; // read mux
	reg rd_ok; // read offset mapped
	reg wr_ok; // write offset mapped
	reg [35:0] step_word; // {addr, data} of the current step
	reg [2:0] last_step; // index of the final bus cycle
	reg refuse; // command cannot be issued now
	wire is_read_op;
	wire new_cmd;
	wire [31:0] status_word;
	assign is_read_op = (op_reg == `FC_OP_READ);
	assign new_cmd = wr_en & (wr_addr == `FC_REG_CTRL) & wr_strb[0];
	assign FL_RESET_N = reset_n_reg;
	// lockout override is an external 12 v switch on the reset pin
	assign FL_HV_EN = hv_reg;
	// ****************************************
	// command sequence table
	// ****************************************
	// unlock cycles use the low sixteen address bits and low data byte only
	always @* begin
		step_word = {`FC_UNLOCK_ADDR1, `FC_UNLOCK_DATA1};
		last_step = 3'd5;
		case (step_reg)
		3'd0: step_word = {`FC_UNLOCK_ADDR1, `FC_UNLOCK_DATA1};
		3'd1: step_word = {`FC_UNLOCK_ADDR2, `FC_UNLOCK_DATA2};
		3'd2: begin
			// third byte names the command family
			case (op_reg)
			`FC_OP_PROG: step_word = {`FC_UNLOCK_ADDR1, `FC_CODE_PROG};
			`FC_OP_ID_ENTRY: step_word = {`FC_UNLOCK_ADDR1, `FC_CODE_ID_ENTRY};
			`FC_OP_ID_EXIT: step_word = {`FC_UNLOCK_ADDR1, `FC_CODE_ID_EXIT};
			default: step_word = {`FC_UNLOCK_ADDR1, `FC_CODE_ERASE};
			endcase
		end
		3'd3: begin
			if (op_reg == `FC_OP_PROG) begin
				step_word = {addr_reg, wdata_reg};
			end else begin
				step_word = {`FC_UNLOCK_ADDR1, `FC_UNLOCK_DATA1};
			end
		end
		3'd4: step_word = {`FC_UNLOCK_ADDR2, `FC_UNLOCK_DATA2};
		default: begin
			// sixth byte picks erase kind, lockout or bypass
			case (op_reg)
			`FC_OP_CHIP_ERASE: step_word = {`FC_UNLOCK_ADDR1, `FC_CODE_CHIP};
			`FC_OP_SECT_ERASE: step_word = {addr_reg, `FC_CODE_SECTOR};
			`FC_OP_LOCKOUT: step_word = {addr_reg, `FC_CODE_LOCK};
			default: step_word = {`FC_UNLOCK_ADDR1, `FC_CODE_PROG};
			endcase
		end
		endcase
		// single-cycle commands override the table
		case (op_reg)
		`FC_OP_PROG: begin
			last_step = bypass_reg ? 3'd0 : 3'd3;
			if (bypass_reg) begin
				step_word = {addr_reg, wdata_reg};
			end
		end
		`FC_OP_SUSPEND: begin
			last_step = 3'd0;
			step_word = {addr_reg, `FC_CODE_SUSPEND};
		end
		`FC_OP_RESUME: begin
			last_step = 3'd0;
			step_word = {addr_reg[19:18], 18'h00000, `FC_CODE_RESUME};
		end
		`FC_OP_ID_EXIT_SHORT: begin
			last_step = 3'd0;
			step_word = {addr_reg, `FC_CODE_ID_EXIT};
		end
		`FC_OP_READ: begin
			last_step = 3'd0;
			step_word = {addr_reg, 16'h0000};
		end
		`FC_OP_ID_ENTRY: last_step = 3'd2;
		`FC_OP_ID_EXIT: last_step = 3'd2;
		default: last_step = 3'd5;
		endcase
	end
	// ****************************************
	// command admission
	// ****************************************
	// erase-class codes in bypass mode would be programmed as data
	always @* begin
		refuse = 1'b0;
		case (wr_data[3:0])
		`FC_OP_CHIP_ERASE, `FC_OP_SECT_ERASE: begin
			refuse = bypass_reg | suspended_reg;
		end
		`FC_OP_LOCKOUT, `FC_OP_BYPASS, `FC_OP_RESUME: refuse = bypass_reg;
		`FC_OP_SUSPEND: refuse = bypass_reg | suspended_reg;
		`FC_OP_ID_ENTRY, `FC_OP_ID_EXIT, `FC_OP_ID_EXIT_SHORT: refuse = bypass_reg;
		`FC_OP_PROG, `FC_OP_READ, `FC_OP_HW_RESET: refuse = 1'b0;
		default: refuse = 1'b1;
		endcase
	end
	// ****************************************
	// ready pin synchroniser
	// ****************************************
	// level moves only when the second and third stages agree
	always @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rdy_sync_reg <= 3'b111;
			rdy_level_reg <= 1'b1;
		end else begin
			rdy_sync_reg <= {rdy_sync_reg[1:0], FL_READY_IN};
			if (rdy_sync_reg[1] == rdy_sync_reg[2]) begin
				rdy_level_reg <= rdy_sync_reg[2];
			end
		end
	end
	// ****************************************
	// sequencer
	// ****************************************
	always @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state_reg <= ST_IDLE;
			op_reg <= `FC_OP_NONE;
			step_reg <= 3'd0;
			wait_reg <= 9'h000;
			addr_reg <= 20'h00000;
			wdata_reg <= 16'h0000;
			hv_reg <= 1'b0;
			bypass_reg <= 1'b0;
			suspended_reg <= 1'b0;
			refused_reg <= 1'b0;
			poll_reg <= 1'b0;
			toggle_reg <= 1'b0;
			sus_toggle_reg <= 1'b0;
			last_rd_reg <= 16'h0000;
			reset_n_reg <= 1'b1;
			cyc_start_reg <= 1'b0;
		end else begin
			cyc_start_reg <= 1'b0;
			// address and data registers honour byte lanes
			if (wr_en & (wr_addr == `FC_REG_ADDR)) begin
				if (wr_strb[0]) addr_reg[7:0] <= wr_data[7:0];
				if (wr_strb[1]) addr_reg[15:8] <= wr_data[15:8];
				if (wr_strb[2]) addr_reg[19:16] <= wr_data[19:16];
			end
			if (wr_en & (wr_addr == `FC_REG_WDATA)) begin
				if (wr_strb[0]) wdata_reg[7:0] <= wr_data[7:0];
				if (wr_strb[1]) wdata_reg[15:8] <= wr_data[15:8];
			end
			if (wr_en & (wr_addr == `FC_REG_CTRL) & wr_strb[1]) begin
				hv_reg <= wr_data[`FC_CTRL_HV_BIT];
			end
			case (state_reg)
			ST_IDLE: begin
				// commands while busy are dropped without setting refused, as the flash would drop them
				if (new_cmd & (wr_data[3:0] != `FC_OP_NONE)) begin
					refused_reg <= refuse;
					if (!refuse) begin
						op_reg <= wr_data[3:0];
						step_reg <= 3'd0;
						wait_reg <= 9'h000;
						if (wr_data[3:0] == `FC_OP_HW_RESET) begin
							reset_n_reg <= 1'b0;
							state_reg <= ST_RESET;
						end else begin
							cyc_start_reg <= 1'b1;
							state_reg <= ST_CYCLE;
						end
					end
				end
			end
			ST_CYCLE: begin
				// sequence runs to its end; no partial sequence is left
				if (cyc_done) begin
					if (step_reg != last_step) begin
						step_reg <= step_reg + 3'd1;
						cyc_start_reg <= 1'b1;
					end else if (is_read_op) begin
						// status bits taken from each read
						last_rd_reg <= cyc_rdata;
						poll_reg <= cyc_rdata[7];
						toggle_reg <= cyc_rdata[6] ^ last_rd_reg[6];
						sus_toggle_reg <= cyc_rdata[2] ^ last_rd_reg[2];
						state_reg <= ST_IDLE;
					end else begin
						case (op_reg)
						`FC_OP_BYPASS: bypass_reg <= 1'b1;
						`FC_OP_RESUME: suspended_reg <= 1'b0;
						default: bypass_reg <= bypass_reg;
						endcase
						// suspend waits out the halt time
						if (op_reg == `FC_OP_SUSPEND) begin
							state_reg <= ST_SUSPEND;
						end else begin
							state_reg <= ST_SETTLE;
						end
					end
				end
			end
			ST_SETTLE: begin
				// give the flash time to pull ready low before trusting it
				if (wait_reg == SETTLE_CYC) begin
					state_reg <= ST_WAIT_RDY;
				end else begin
					wait_reg <= wait_reg + 9'h001;
				end
			end
			ST_WAIT_RDY: begin
				// internal cycle over once the pin is released
				if (rdy_level_reg) begin
					state_reg <= ST_IDLE;
				end
			end
			ST_SUSPEND: begin
				// reads and programs elsewhere allowed afterwards
				if (wait_reg == SUSPEND_CYC) begin
					suspended_reg <= 1'b1;
					state_reg <= ST_IDLE;
				end else begin
					wait_reg <= wait_reg + 9'h001;
				end
			end
			ST_RESET: begin
				// a reset pulse also leaves bypass mode
				if (wait_reg == RST_CYC) begin
					reset_n_reg <= 1'b1;
					bypass_reg <= 1'b0;
					suspended_reg <= 1'b0;
					state_reg <= ST_IDLE;
				end else begin
					wait_reg <= wait_reg + 9'h001;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end
	// ****************************************
	// register read mux and decode
	// ****************************************
	assign status_word = {23'h000000, hv_reg, sus_toggle_reg, toggle_reg, poll_reg,
		refused_reg, suspended_reg, bypass_reg, rdy_level_reg, state_reg != ST_IDLE};
	always @* begin
		rd_ok = 1'b1;
		case (rd_addr)
		`FC_REG_CTRL: rd_data = {23'h000000, hv_reg, 4'h0, op_reg};
		`FC_REG_ADDR: rd_data = {12'h000, addr_reg};
		`FC_REG_WDATA: rd_data = {16'h0000, wdata_reg};
		`FC_REG_STATUS: rd_data = status_word;
		`FC_REG_RDATA: rd_data = {16'h0000, last_rd_reg};
		default: begin
			rd_data = 32'h00000000;
			rd_ok = 1'b0;
		end
		endcase
	end
	// status and read data are read-only but writes are harmless
	always @* begin
		case (wr_addr)
		`FC_REG_CTRL, `FC_REG_ADDR, `FC_REG_WDATA: wr_ok = 1'b1;
		`FC_REG_STATUS, `FC_REG_RDATA: wr_ok = 1'b1;
		default: wr_ok = 1'b0;
		endcase
	end
	// ****************************************
	// sub-blocks
	// ****************************************
	fc_axil_slave u_axil (
		.clk(SYS_CLK),
		.rst(RST),
		.awaddr(S_AXI_AWADDR),
		.awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY),
		.wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB),
		.wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY),
		.bresp_reg(S_AXI_BRESP),
		.bvalid_reg(S_AXI_BVALID),
		.bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR),
		.arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY),
		.rdata_reg(S_AXI_RDATA),
		.rresp_reg(S_AXI_RRESP),
		.rvalid_reg(S_AXI_RVALID),
		.rready(S_AXI_RREADY),
		.wr_en(wr_en),
		.wr_addr_reg(wr_addr),
		.wr_data_reg(wr_data),
		.wr_strb_reg(wr_strb),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);
	// pins of one bus cycle; strobes always pulse through this block
	fc_bus_cycle u_cycle (
		.clk(SYS_CLK),
		.rst(RST),
		.start(cyc_start_reg),
		.is_read(is_read_op),
		.addr(step_word[35:16]),
		.wdata(step_word[15:0]),
		.done(cyc_done),
		.rdata_reg(cyc_rdata),
		.pin_addr_reg(FL_ADDR),
		.pin_dq_out_reg(FL_DQ_OUT),
		.pin_dq_oe_reg(FL_DQ_OE),
		.pin_ce_n_reg(FL_CE_N),
		.pin_oe_n_reg(FL_OE_N),
		.pin_we_n_reg(FL_WE_N),
		.pin_dq_in(FL_DQ_IN)
	);
endmodule // fc_flash_host

// *** verification/fc_flash_props.sv ***
/* pin and bus checks on the flash host.
 assumes binding to fc_flash_host, ports only. */
`timescale 1ns/1ps
module fc_flash_props (
	// clock, reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// axi handshakes
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	// flash pins
	input wire logic [19:0] FL_ADDR,
	input wire logic [15:0] FL_DQ_OUT,
	input wire logic FL_DQ_OE,
	input wire logic FL_CE_N,
	input wire logic FL_OE_N,
	input wire logic FL_WE_N,
	input wire logic FL_RESET_N
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	rst_quiet_a: assert property ($fell(RST) |-> FL_CE_N && FL_WE_N && FL_OE_N)
		else $error("pins active after reset");
	we_qual_a: assert property (!FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_DQ_OE)
		else $error("strobe without select");
	we_width_a: assert property ($fell(FL_WE_N) |=> !FL_WE_N ##1 FL_WE_N)
		else $error("strobe width");
	we_hold_a: assert property (!FL_WE_N |-> $stable(FL_ADDR) && $stable(FL_DQ_OUT))
		else $error("pins move in strobe");
	oe_nodrive_a: assert property (!FL_OE_N |-> !FL_DQ_OE && FL_WE_N)
		else $error("drive while reading");
	rst_pulse_a: assert property ($fell(FL_RESET_N) |=> !FL_RESET_N[*8] ##[1:8] FL_RESET_N)
		else $error("reset pulse length");
	aw_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
		else $error("aw ready during b");
	r_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
endmodule // fc_flash_props
bind fc_flash_host fc_flash_props i_fc_flash_props (.*);

// *** verification/fc_flash_model.sv ***
/* behavioural flash: program, chip erase, bypass, status bits.
 assumes host pins only; clock just times the busy span. */
`timescale 1ns/1ps
module fc_flash_model (
	// timing clock
	input wire logic SYS_CLK,
	// host pins
	input wire logic [19:0] FL_ADDR,
	input wire logic [15:0] FL_DQ_OUT,
	input wire logic FL_CE_N,
	input wire logic FL_OE_N,
	input wire logic FL_WE_N,
	input wire logic FL_RESET_N,
	// device outputs
	output wire logic [15:0] FL_DQ_IN,
	output wire logic FL_READY_IN
);
	logic [15:0] mem [int]; // written words, rest erased
	logic [15:0] ld = 0; // last loaded word
	logic tg = 0, er = 0, byp = 0;
	int st = 0, bsy = 0;
	function automatic logic [15:0] rdm(input logic [19:0] x);
		return mem.exists(x) ? mem[x] : 16'hffff;
	endfunction
	// released bus shows a moving pattern so stale data never passes
	assign FL_DQ_IN = (FL_CE_N || FL_OE_N) ? ~FL_ADDR[15:0] : !bsy ? rdm(FL_ADDR) :
		{ld[15:8], !er && !ld[7], tg, ld[5:0]};
	assign FL_READY_IN = bsy == 0;
	always @(posedge SYS_CLK) if (bsy > 0) bsy--;
	always @(negedge FL_OE_N) if (!FL_CE_N && bsy) tg = !tg;
	always @(negedge FL_RESET_N) begin
		bsy = 0; st = 0; byp = 0;
	end
	// decode at the strobe rise; busy device drops commands
	always @(posedge FL_WE_N) if (!FL_CE_N && FL_OE_N && FL_RESET_N && !bsy) begin
		if (byp || st == 3) begin
			mem[FL_ADDR] = rdm(FL_ADDR) & FL_DQ_OUT; ld = FL_DQ_OUT; er = 0; bsy = 30; st = 0;
		end else if (FL_DQ_OUT[7:0] == 8'haa && FL_ADDR[15:0] == 16'h5555 && st % 4 == 0) st++;
		else if (FL_DQ_OUT[7:0] == 8'h55 && FL_ADDR[15:0] == 16'h2aaa && st % 4 == 1) st++;
		else if (st == 2) st = FL_DQ_OUT[7:0] == 8'ha0 ? 3 : FL_DQ_OUT[7:0] == 8'h80 ? 4 : 0;
		else if (st == 6 && FL_DQ_OUT[7:0] == 8'h10) begin
			mem.delete(); er = 1; bsy = 60; st = 0;
		end else begin
			byp = st == 6 && FL_DQ_OUT[7:0] == 8'ha0; st = 0;
		end
	end
endmodule // fc_flash_model

// *** verification/fc_flash_host_test.sv ***
/* self-checking bench for the flash host over axi4-lite.
 assumes fc_flash_model on the pins, fc_flash_props bound. */
`timescale 1ns/1ps
`include "fc_flash_regs.vh"
module fc_flash_host_test;
	logic SYS_CLK = 0, RST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
	logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
	logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
	logic [31:0] S_AXI_WDATA = 0, rdv;
	logic [3:0] S_AXI_WSTRB = 4'hf;
	wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
	wire [31:0] S_AXI_RDATA;
	wire FL_DQ_OE, FL_CE_N, FL_OE_N, FL_WE_N, FL_RESET_N, FL_HV_EN, FL_READY_IN;
	wire [19:0] FL_ADDR;
	wire [15:0] FL_DQ_OUT, FL_DQ_IN;
	int mismatches = 0, n_tests = 0;
	logic [1:0] bq [$];
	logic [65:0] rq [$], n;
	fc_flash_host i_fc_flash_host (.*);
	fc_flash_model i_fc_flash_model (.*);
	always #20 SYS_CLK = !SYS_CLK;
	// answers are checked against the oldest note
	always @(posedge SYS_CLK) begin
		if (S_AXI_RVALID && S_AXI_RREADY && rq.size()) begin
			n = rq.pop_front();
			n_tests++;
			if (({S_AXI_RRESP, S_AXI_RDATA & n[65:34]}) !== n[33:0]) begin
				mismatches++;
				$display("Error rdata exp %h got %h", n[33:0], {S_AXI_RRESP, S_AXI_RDATA});
			end
		end
		if (S_AXI_BVALID && S_AXI_BREADY && bq.size()) begin
			n_tests++;
			if (S_AXI_BRESP !== bq[0]) begin
				mismatches++;
				$display("Error bresp exp %h got %h", bq[0], S_AXI_BRESP);
			end
			void'(bq.pop_front());
		end
	end
	task wr(input [7:0] a, input [31:0] d, input [1:0] r);
		bit ta, tw;
		bq.push_back(r);
		@(posedge SYS_CLK);
		{S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
		{ta, tw} = 0;
		while (!(ta && tw)) begin
			@(posedge SYS_CLK);
			ta |= S_AXI_AWREADY;
			tw |= S_AXI_WREADY;
			{S_AXI_AWVALID, S_AXI_WVALID} <= {!ta, !tw};
		end
		do @(posedge SYS_CLK); while (!S_AXI_BVALID);
		S_AXI_BREADY <= 0;
	endtask
	task rd(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] r);
		rq.push_back({m, r, e});
		@(posedge SYS_CLK);
		{S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'h3};
		do @(posedge SYS_CLK); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 0;
		do @(posedge SYS_CLK); while (!S_AXI_RVALID);
		rdv = S_AXI_RDATA;
		S_AXI_RREADY <= 0;
	endtask
	// load address and data, start a command, poll until idle
	task cmd(input [31:0] c, input [19:0] a, input [15:0] d);
		wr(`FC_REG_ADDR, a, 0);
		wr(`FC_REG_WDATA, d, 0);
		wr(`FC_REG_CTRL, c, 0);
		do rd(`FC_REG_STATUS, 0, 0, 0); while (rdv[0] !== 0);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#2000000;
		mismatches++;
		wrap_up;
	end
	initial begin
		logic [19:0] a;
		logic [15:0] d1, d2;
		a = $urandom(21);
		repeat (2) @(posedge SYS_CLK);
		RST <= 0;
		rd(`FC_REG_STATUS, 32'h2, 32'h1ff, 0);
		rd(8'h20, 0, 32'hffffffff, 2'b10);
		wr(8'h24, 1, 2'b10);
		repeat (3) begin
			a = $urandom;
			d1 = $urandom;
			d2 = $urandom;
			cmd(`FC_OP_PROG, a, d1);
			cmd(`FC_OP_PROG, a, d2);
			cmd(`FC_OP_READ, a, 0);
			rd(`FC_REG_RDATA, d1 & d2, 32'hffff, 0);
		end
		cmd(`FC_OP_CHIP_ERASE, 0, 0);
		cmd(`FC_OP_READ, a, 0);
		rd(`FC_REG_RDATA, 32'hffff, 32'hffff, 0);
		cmd(`FC_OP_BYPASS, 0, 0);
		rd(`FC_REG_STATUS, 32'h4, 32'h14, 0);
		cmd(`FC_OP_CHIP_ERASE, 0, 0);
		rd(`FC_REG_STATUS, 32'h14, 32'h14, 0);
		cmd(`FC_OP_PROG, a, d1);
		cmd(`FC_OP_READ, a, 0);
		rd(`FC_REG_RDATA, d1, 32'hffff, 0);
		cmd(`FC_OP_HW_RESET, 0, 0);
		rd(`FC_REG_STATUS, 0, 32'h4, 0);
		cmd(`FC_OP_SUSPEND, a, 0);
		rd(`FC_REG_STATUS, 32'ha, 32'h1f, 0);
		cmd(`FC_OP_SECT_ERASE, a, 0);
		rd(`FC_REG_STATUS, 32'h1a, 32'h1f, 0);
		cmd(`FC_OP_RESUME, a, 0);
		rd(`FC_REG_STATUS, 32'h2, 32'h1f, 0);
		cmd(`FC_OP_ID_ENTRY, a, 0);
		cmd(`FC_OP_ID_EXIT, a, 0);
		cmd(`FC_OP_ID_EXIT_SHORT, a, 0);
		cmd(`FC_OP_LOCKOUT, a, 0);
		rd(`FC_REG_STATUS, 32'h2, 32'h1f, 0);
		cmd(32'hd, 0, 0);
		rd(`FC_REG_STATUS, 32'h10, 32'h10, 0);
		cmd(32'h100, 0, 0);
		rd(`FC_REG_STATUS, 32'h100, 32'h100, 0);
		n_tests++;
		if (FL_HV_EN !== 1'b1) begin
			mismatches++;
			$display("Error hv_en exp 1 got %b", FL_HV_EN);
		end
		wrap_up;
	end
endmodule // fc_flash_host_test
